// ### acec_pkg.sv
// Constants shared by the axis command error checker
`default_nettype none
package acec_pkg;
   localparam int AXES  = 16;
   localparam int ERR_W = 10;

   // Register byte addresses
   localparam logic [7:0] A_CMD    = 8'h00;
   localparam logic [7:0] A_TARGET = 8'h04;
   localparam logic [7:0] A_FSLIM  = 8'h08;
   localparam logic [7:0] A_RSLIM  = 8'h0C;
   localparam logic [7:0] A_OVR    = 8'h10;
   localparam logic [7:0] A_FEED   = 8'h14;
   localparam logic [7:0] A_SEL    = 8'h18;
   localparam logic [7:0] A_STAT   = 8'h1C;
   localparam logic [7:0] A_ERRSUM = 8'h20;
   localparam logic [7:0] A_POS    = 8'h24;

   // Field positions
   localparam int CMD_AX_LSB   = 0;
   localparam int CMD_CODE_LSB = 4;
   localparam int OVR_AX_LSB   = 16;
   localparam int FEED_AX_LSB  = 24;
   localparam int FEED_D_W     = 24;

   // Command codes
   localparam logic [3:0] C_NOP        = 4'h0;
   localparam logic [3:0] C_JOG_FWD    = 4'h1;
   localparam logic [3:0] C_JOG_REV    = 4'h2;
   localparam logic [3:0] C_POSN       = 4'h3;
   localparam logic [3:0] C_ORG_SEARCH = 4'h4;
   localparam logic [3:0] C_ORG_RETURN = 4'h5;
   localparam logic [3:0] C_PRESET     = 4'h6;
   localparam logic [3:0] C_ERR_RESET  = 4'h7;
   localparam logic [3:0] C_MOVE_DONE  = 4'h8;
   localparam logic [3:0] C_ORG_FOUND  = 4'h9;

   // Error bit positions
   localparam int E_MULTI = 0;
   localparam int E_SERVO = 1;
   localparam int E_FLIM  = 2;
   localparam int E_RLIM  = 3;
   localparam int E_FSW   = 4;
   localparam int E_RSW   = 5;
   localparam int E_UNK   = 6;
   localparam int E_DCR   = 7;
   localparam int E_OVR   = 8;
   localparam int E_OVF   = 9;
   localparam logic [ERR_W-1:0] DECEL_MASK = 10'h3A1;

   // Values after reset and limits
   localparam logic [31:0] FSLIM_RST = 32'h7FFFFFFF;
   localparam logic [31:0] RSLIM_RST = 32'h80000000;
   localparam logic [15:0] OVR_RST   = 16'h0064;
   localparam logic [15:0] OVR_MAX   = 16'h01F4;
   localparam logic signed [32:0] POS_UPPER = 33'sh07FFFFFFF;
   localparam logic signed [32:0] POS_LOWER = 33'sh180000000;
   localparam logic [7:0]  AE_PREFIX = 8'hAE;
endpackage
`default_nettype wire

// ### acec_mem_if.sv
// Port bundle between the checker and its position store
`timescale 1ns/10ps
`default_nettype none
interface acec_mem_if;
   logic [3:0]  addr;
   logic        we;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport ctrl  (output addr, output we, output wdata, input rdata);
   modport store (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// ### acec_pos_mem.sv
// Command present position store, one word per axis, registered read
`timescale 1ns/10ps
`default_nettype none
module acec_pos_mem (
   input  wire logic     mclk_i,
   acec_mem_if.store     m
);
   logic [31:0] mem [16];
   logic [31:0] rd;

   always_ff @(posedge mclk_i) begin
      if (m.we) begin
         mem[m.addr] <= m.wdata;
      end
      rd <= mem[m.addr];
   end
   assign m.rdata = rd;
endmodule
`default_nettype wire

// ### acec_top.sv
// Axis command error checker with APB register access
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module acec_top
   import acec_pkg::*;
(
   input  wire logic              mclk_i,
   input  wire logic              nrst_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [7:0]        paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic [31:0]            prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   input  wire logic [AXES-1:0]   servo_lock_i,
   input  wire logic [AXES-1:0]   fwd_limit_i,
   input  wire logic [AXES-1:0]   rev_limit_i,
   input  wire logic [AXES-1:0]   counter_reset_i,
   output logic [AXES-1:0]        axis_busy_o,
   output logic [AXES-1:0]        axis_decel_o,
   output logic                   unit_error_lamp_o,
   output logic [15:0]            segment_display_code_o
);

   typedef struct packed {
      logic [AXES-1:0]            s1_lock;
      logic [AXES-1:0]            s2_lock;
      logic [AXES-1:0]            s1_flim;
      logic [AXES-1:0]            s2_flim;
      logic [AXES-1:0]            s1_rlim;
      logic [AXES-1:0]            s2_rlim;
      logic [AXES-1:0]            s1_dcr;
      logic [AXES-1:0]            s2_dcr;
      logic [AXES-1:0]            s3_dcr;
      logic [AXES-1:0]            busy;
      logic [AXES-1:0]            searching;
      logic [AXES-1:0]            origin_def;
      logic [AXES-1:0]            ovf;
      logic [AXES-1:0]            decel;
      logic [AXES-1:0][ERR_W-1:0] err;
      logic [31:0]                target;
      logic [31:0]                fslim;
      logic [31:0]                rslim;
      logic [15:0]                override;
      logic [3:0]                 sel;
      logic                       ph;
      logic                       pready;
      logic                       pslverr;
      logic [31:0]                prdata;
      logic                       lamp;
      logic [15:0]                seg;
   } acec_state_t;

   acec_state_t q;
   acec_state_t next_q;
   acec_mem_if  mif ();

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == A_CMD) || (a == A_TARGET) || (a == A_FSLIM) || (a == A_RSLIM) ||
                  (a == A_OVR) || (a == A_FEED) || (a == A_SEL) || (a == A_STAT) ||
                  (a == A_ERRSUM) || (a == A_POS);
   endfunction

   function automatic logic is_start(input logic [3:0] c);
      is_start = (c >= C_JOG_FWD) && (c <= C_ORG_RETURN);
   endfunction

   function automatic logic [AXES-1:0] err_vec(input logic [AXES-1:0][ERR_W-1:0] e);
      for (int i = 0; i < AXES; i++) begin
         err_vec[i] = |e[i];
      end
   endfunction

   function automatic logic [3:0] first_err(input logic [AXES-1:0] v);
      first_err = 4'h0;
      for (int i = AXES - 1; i >= 0; i--) begin
         if (v[i]) begin
            first_err = 4'(i);
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Request decode
   logic                 commit;
   logic                 wr;
   logic [3:0]           cmd_ax;
   logic [3:0]           cmd_code;
   logic [3:0]           ovr_ax;
   logic [3:0]           feed_ax;
   logic signed [32:0]   pos_sum;
   logic [AXES-1:0]      err_any;

   assign commit   = q.pready && psel_i && penable_i;
   assign wr       = commit && pwrite_i && is_mapped(paddr_i);
   assign cmd_ax   = pwdata_i[CMD_AX_LSB +: 4];
   assign cmd_code = pwdata_i[CMD_CODE_LSB +: 4];
   assign ovr_ax   = pwdata_i[OVR_AX_LSB +: 4];
   assign feed_ax  = pwdata_i[FEED_AX_LSB +: 4];
   assign pos_sum  = $signed({mif.rdata[31], mif.rdata}) +
                     33'($signed(pwdata_i[FEED_D_W-1:0]));
   assign err_any  = err_vec(q.err);

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_q         = q;
      next_q.s1_lock = servo_lock_i;
      next_q.s2_lock = q.s1_lock;
      next_q.s1_flim = fwd_limit_i;
      next_q.s2_flim = q.s1_flim;
      next_q.s1_rlim = rev_limit_i;
      next_q.s2_rlim = q.s1_rlim;
      next_q.s1_dcr  = counter_reset_i;
      next_q.s2_dcr  = q.s1_dcr;
      next_q.s3_dcr  = q.s2_dcr;
      mif.addr       = q.sel;
      mif.we         = 1'b0;
      mif.wdata      = 32'h00000000;
      if (paddr_i == A_CMD) begin
         mif.addr = cmd_ax;
      end else if (paddr_i == A_FEED) begin
         mif.addr = feed_ax;
      end

      // Bus timing: address phase, data phase, then answer
      next_q.pready  = 1'b0;
      next_q.pslverr = 1'b0;
      if (q.pready) begin
         next_q.ph = 1'b0;
      end else if (psel_i && penable_i && !q.ph) begin
         next_q.ph = 1'b1;
      end else if (psel_i && penable_i && q.ph) begin
         next_q.pready  = 1'b1;
         next_q.pslverr = !is_mapped(paddr_i);
         unique case (paddr_i)
            A_TARGET: next_q.prdata = q.target;
            A_FSLIM:  next_q.prdata = q.fslim;
            A_RSLIM:  next_q.prdata = q.rslim;
            A_OVR:    next_q.prdata = {16'h0000, q.override};
            A_SEL:    next_q.prdata = {28'h0000000, q.sel};
            A_STAT:   next_q.prdata = {15'h0000, q.s2_lock[q.sel], q.ovf[q.sel],
                                       q.origin_def[q.sel], q.searching[q.sel],
                                       q.busy[q.sel], q.decel[q.sel], 1'b0, q.err[q.sel]};
            A_ERRSUM: next_q.prdata = {12'h000, first_err(err_any), err_any};
            A_POS:    next_q.prdata = mif.rdata;
            default:  next_q.prdata = 32'h00000000;
         endcase
      end

      // Plain register writes
      if (wr) begin
         unique case (paddr_i)
            A_TARGET: next_q.target = pwdata_i;
            A_FSLIM:  next_q.fslim  = pwdata_i;
            A_RSLIM:  next_q.rslim  = pwdata_i;
            A_SEL:    next_q.sel    = pwdata_i[3:0];
            default: begin
            end
         endcase
      end

      // Error reset clears first so that same-cycle events still set
      if (wr && paddr_i == A_CMD && cmd_code == C_ERR_RESET) begin
         next_q.err[cmd_ax] = '0;
      end

      // Counter reset seen while searching for the origin
      for (int i = 0; i < AXES; i++) begin
         if (q.searching[i] && q.s2_dcr[i] && !q.s3_dcr[i]) begin
            next_q.err[i][E_DCR] = 1'b1;
         end
      end

      // Override check on each write
      if (wr && paddr_i == A_OVR) begin
         next_q.override = pwdata_i[15:0];
         if (pwdata_i[15:0] > OVR_MAX) begin
            next_q.err[ovr_ax][E_OVR] = 1'b1;
         end
      end

      // Position feed with range check
      if (wr && paddr_i == A_FEED && !q.ovf[feed_ax]) begin
         if (pos_sum > POS_UPPER || pos_sum < POS_LOWER) begin
            next_q.err[feed_ax][E_OVF] = 1'b1;
            next_q.ovf[feed_ax]        = 1'b1;
         end else begin
            mif.we    = 1'b1;
            mif.wdata = pos_sum[31:0];
         end
      end

      // Axis operation commands
      if (wr && paddr_i == A_CMD) begin
         if (cmd_code == C_MOVE_DONE) begin
            next_q.busy[cmd_ax] = 1'b0;
         end else if (cmd_code == C_ORG_FOUND && q.searching[cmd_ax]) begin
            next_q.searching[cmd_ax]  = 1'b0;
            next_q.busy[cmd_ax]       = 1'b0;
            next_q.origin_def[cmd_ax] = 1'b1;
            next_q.ovf[cmd_ax]        = 1'b0;
            mif.we                    = 1'b1;
         end else if (cmd_code == C_PRESET && q.err[cmd_ax] == '0) begin
            next_q.origin_def[cmd_ax] = 1'b1;
            next_q.ovf[cmd_ax]        = 1'b0;
            mif.we                    = 1'b1;
            mif.wdata                 = q.target;
         end else if (is_start(cmd_code) && q.err[cmd_ax] == '0) begin
            if (!q.s2_lock[cmd_ax]) begin
               next_q.err[cmd_ax][E_SERVO] = 1'b1;
            end else if (q.s2_dcr[cmd_ax]) begin
               next_q.err[cmd_ax][E_DCR] = 1'b1;
            end else if (q.busy[cmd_ax]) begin
               next_q.err[cmd_ax][E_MULTI] = 1'b1;
            end else begin
               unique case (cmd_code)
                  C_JOG_FWD: begin
                     if (q.s2_flim[cmd_ax]) begin
                        next_q.err[cmd_ax][E_FLIM] = 1'b1;
                     end else begin
                        next_q.busy[cmd_ax] = 1'b1;
                     end
                  end
                  C_JOG_REV: begin
                     if (q.s2_rlim[cmd_ax]) begin
                        next_q.err[cmd_ax][E_RLIM] = 1'b1;
                     end else begin
                        next_q.busy[cmd_ax] = 1'b1;
                     end
                  end
                  C_POSN: begin
                     if ($signed(q.target) > $signed(q.fslim)) begin
                        next_q.err[cmd_ax][E_FSW] = 1'b1;
                     end else if ($signed(q.target) < $signed(q.rslim)) begin
                        next_q.err[cmd_ax][E_RSW] = 1'b1;
                     end else begin
                        next_q.busy[cmd_ax] = 1'b1;
                     end
                  end
                  C_ORG_SEARCH: begin
                     next_q.busy[cmd_ax]      = 1'b1;
                     next_q.searching[cmd_ax] = 1'b1;
                  end
                  C_ORG_RETURN: begin
                     if (!q.origin_def[cmd_ax]) begin
                        next_q.err[cmd_ax][E_UNK] = 1'b1;
                     end else begin
                        next_q.busy[cmd_ax] = 1'b1;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
      end

      // Decelerating errors stop the axis and hold it until reset
      for (int i = 0; i < AXES; i++) begin
         next_q.decel[i] = |(next_q.err[i] & DECEL_MASK);
         if (next_q.decel[i]) begin
            next_q.busy[i]      = 1'b0;
            next_q.searching[i] = 1'b0;
         end
      end

      // Error display
      next_q.lamp = |err_any;
      next_q.seg  = (|err_any) ? {AE_PREFIX, 8'(first_err(err_any)) + 8'h01} : 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q          <= '0;
         q.fslim    <= FSLIM_RST;
         q.rslim    <= RSLIM_RST;
         q.override <= OVR_RST;
      end else begin
         q <= next_q;
      end
   end

   acec_pos_mem u_mem (
      .mclk_i (mclk_i),
      .m      (mif.store)
   );

   assign prdata_o               = q.prdata;
   assign pready_o               = q.pready;
   assign pslverr_o              = q.pslverr;
   assign axis_busy_o            = q.busy;
   assign axis_decel_o           = q.decel;
   assign unit_error_lamp_o      = q.lamp;
   assign segment_display_code_o = q.seg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   logic go_ok;
   assign go_ok = wr && paddr_i == A_CMD && is_start(cmd_code) && q.err[cmd_ax] == '0;

   sequence s_err_set(int b);
      q.err[$past(cmd_ax)][b] ##1 unit_error_lamp_o;
   endsequence

   a_multi_start: assert property (go_ok && q.s2_lock[cmd_ax] && !q.s2_dcr[cmd_ax] && q.busy[cmd_ax]
      |=> s_err_set(E_MULTI) and (axis_decel_o[$past(cmd_ax)] ##1 1'b1))
      else $error("multi-start not flagged");
   a_servo_unlock: assert property (go_ok && !q.s2_lock[cmd_ax]
      |=> s_err_set(E_SERVO) and ((axis_busy_o[$past(cmd_ax)] == $past(q.busy[cmd_ax])) ##1 1'b1))
      else $error("unlocked command not rejected");
   a_fwd_limit: assert property (go_ok && cmd_code == C_JOG_FWD && q.s2_lock[cmd_ax] &&
      !q.s2_dcr[cmd_ax] && !q.busy[cmd_ax] && q.s2_flim[cmd_ax] |=> s_err_set(E_FLIM))
      else $error("forward limit start not flagged");
   a_rev_limit: assert property (go_ok && cmd_code == C_JOG_REV && q.s2_lock[cmd_ax] &&
      !q.s2_dcr[cmd_ax] && !q.busy[cmd_ax] && q.s2_rlim[cmd_ax] |=> s_err_set(E_RLIM))
      else $error("reverse limit start not flagged");
   a_rev_soft: assert property (go_ok && cmd_code == C_POSN && q.s2_lock[cmd_ax] &&
      !q.s2_dcr[cmd_ax] && !q.busy[cmd_ax] && $signed(q.target) < $signed(q.rslim) &&
      $signed(q.target) <= $signed(q.fslim) |=> axis_decel_o[$past(cmd_ax)])
      else $error("reverse soft limit not stopping axis");
   a_origin_unknown: assert property (go_ok && cmd_code == C_ORG_RETURN && q.s2_lock[cmd_ax] &&
      !q.s2_dcr[cmd_ax] && !q.busy[cmd_ax] && !q.origin_def[cmd_ax] |=> s_err_set(E_UNK))
      else $error("origin return without origin not flagged");
   a_override_range: assert property (wr && paddr_i == A_OVR && pwdata_i[15:0] > OVR_MAX
      |=> axis_decel_o[$past(ovr_ax)] && q.err[$past(ovr_ax)][E_OVR])
      else $error("override out of range not flagged");
   a_error_latched: assert property (!(wr && paddr_i == A_CMD && cmd_code == C_ERR_RESET)
      |=> (q.err & $past(q.err)) == $past(q.err))
      else $error("error cleared without reset");
   a_display_code: assert property (|err_any |=> unit_error_lamp_o &&
      segment_display_code_o[15:8] == AE_PREFIX && segment_display_code_o[7:0] != 8'h00)
      else $error("error display wrong");
endmodule
`default_nettype wire

// ### acec_drive_model.sv
// Servo drive side model: lock, limit and counter reset levels per axis
`timescale 1ns/10ps
`default_nettype none
module acec_drive_model
   import acec_pkg::*;
(
   input  wire logic            mclk_i,
   input  wire logic            nrst_i,
   input  wire logic [AXES-1:0] lock_req_i,
   input  wire logic [AXES-1:0] fwd_req_i,
   input  wire logic [AXES-1:0] rev_req_i,
   input  wire logic [AXES-1:0] dcr_req_i,
   output logic      [AXES-1:0] servo_lock_o,
   output logic      [AXES-1:0] fwd_limit_o,
   output logic      [AXES-1:0] rev_limit_o,
   output logic      [AXES-1:0] counter_reset_o
);
   // Drives come up unlocked, no limit, no counter reset; levels follow one cycle late
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         servo_lock_o    <= '0;
         fwd_limit_o     <= '0;
         rev_limit_o     <= '0;
         counter_reset_o <= '0;
      end else begin
         servo_lock_o    <= lock_req_i;
         fwd_limit_o     <= fwd_req_i;
         rev_limit_o     <= rev_req_i;
         counter_reset_o <= dcr_req_i;
      end
   end
endmodule
`default_nettype wire

// ### test_axis_command_error_checker.sv
// Self-checking bench for the axis command error checker
`timescale 1ns/10ps
`default_nettype none
module test_axis_command_error_checker
   import acec_pkg::*;
();
   logic             mclk_i = 1'b0;
   logic             nrst_i = 1'b0;
   logic             psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h00000000, prdata, r;
   logic             pready, pslverr, e, lamp;
   logic [15:0]      seg;
   logic [AXES-1:0]  lock_req = '0, fwd_req = '0, rev_req = '0, dcr_req = '0;
   logic [AXES-1:0]  lock, flim, rlim, dcr, busy, decel;
   logic [ERR_W-1:0] m_err [AXES];
   bit               m_busy [AXES], m_org [AXES], m_ovf [AXES];
   longint           m_pos [AXES], m_tgt, m_fs, m_rs;
   logic [31:0]      rng = 32'h000186B9;
   int               bad_count = 0, cmp_count = 0;

   always #2.5 mclk_i = ~mclk_i;

   acec_top u_acec_top (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .servo_lock_i(lock), .fwd_limit_i(flim), .rev_limit_i(rlim), .counter_reset_i(dcr),
      .axis_busy_o(busy), .axis_decel_o(decel), .unit_error_lamp_o(lamp), .segment_display_code_o(seg));
   acec_drive_model u_acec_drive_model (.mclk_i(mclk_i), .nrst_i(nrst_i), .lock_req_i(lock_req),
      .fwd_req_i(fwd_req), .rev_req_i(rev_req), .dcr_req_i(dcr_req), .servo_lock_o(lock),
      .fwd_limit_o(flim), .rev_limit_o(rlim), .counter_reset_o(dcr));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   task automatic stop_test();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      cmp_count++;
      if (g !== x) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, x, g);
      end
   endtask

   // APB master: setup, access held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic er);
      int n;
      @(posedge mclk_i);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         stop_test();
      end
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rdck(input string nm, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h00000000, r, e);
      chk(nm, x, r);
   endtask

   task automatic flag(input int ax, input int b);
      m_err[ax][b] = 1'b1;
      if (DECEL_MASK[b]) m_busy[ax] = 1'b0;
   endtask

   // Command with the reference model of the checks and their priority
   task automatic cmd(input int ax, input logic [3:0] c);
      int b;
      wr(A_CMD, {24'h000000, c, ax[3:0]});
      if (m_err[ax] != '0 && c != C_ERR_RESET && c != C_MOVE_DONE && c != C_ORG_FOUND) return;
      b = -1;
      case (c)
         C_ERR_RESET: m_err[ax] = '0;
         C_MOVE_DONE: m_busy[ax] = 1'b0;
         C_PRESET, C_ORG_FOUND: begin
            m_pos[ax] = (c == C_PRESET) ? m_tgt : 0;
            m_org[ax] = 1'b1;
            m_ovf[ax] = 1'b0;
         end
         default: begin
            if (!lock[ax]) b = E_SERVO;
            else if (dcr[ax]) b = E_DCR;
            else if (m_busy[ax]) b = E_MULTI;
            else if (c == C_JOG_FWD && flim[ax]) b = E_FLIM;
            else if (c == C_JOG_REV && rlim[ax]) b = E_RLIM;
            else if (c == C_POSN && m_tgt > m_fs) b = E_FSW;
            else if (c == C_POSN && m_tgt < m_rs) b = E_RSW;
            else if (c == C_ORG_RETURN && !m_org[ax]) b = E_UNK;
            if (b >= 0) flag(ax, b);
            else m_busy[ax] = 1'b1;
         end
      endcase
   endtask

   task automatic feed(input int ax, input int d);
      longint np;
      wr(A_FEED, {4'h0, ax[3:0], d[23:0]});
      np = m_pos[ax] + d;
      if (!m_ovf[ax] && (np > longint'(POS_UPPER) || np < longint'(POS_LOWER))) begin
         flag(ax, E_OVF);
         m_ovf[ax] = 1'b1;
      end else if (!m_ovf[ax]) begin
         m_pos[ax] = np;
      end
   endtask

   task automatic stat(input int ax);
      wr(A_SEL, ax);
      apb(1'b0, A_STAT, 32'h00000000, r, e);
      chk("stat_err", m_err[ax], r[9:0]);
      chk("stat_busy", m_busy[ax], r[12]);
   endtask

   task automatic posck(input int ax);
      wr(A_SEL, ax);
      rdck("pos", A_POS, m_pos[ax][31:0]);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end

   initial begin
      logic [31:0] x;
      int lo;
      for (int i = 0; i < AXES; i++) begin
         m_err[i] = '0;
         m_busy[i] = 1'b0;
         m_org[i] = 1'b0;
         m_ovf[i] = 1'b0;
      end
      m_fs = FSLIM_RST;
      m_rs = -longint'(32'h80000000);
      repeat (16) @(posedge mclk_i);
      nrst_i <= 1'b1;
      lock_req <= 16'hFFFE;
      fwd_req <= 16'h0002;
      rev_req <= 16'h0004;
      dcr_req <= 16'h0040;
      @(negedge mclk_i);
      chk("lamp_rst", 32'h0, lamp);
      chk("seg_rst", 32'h0, seg);
      rdck("fslim", A_FSLIM, FSLIM_RST);
      rdck("rslim", A_RSLIM, RSLIM_RST);
      rdck("ovr", A_OVR, {16'h0000, OVR_RST});
      rdck("unmapped", 8'h40, 32'h00000000);
      chk("slverr", 32'h1, e);
      cmd(0, C_JOG_FWD);
      stat(0);
      @(negedge mclk_i);
      chk("lamp", 32'h1, lamp);
      chk("seg", {16'h0000, AE_PREFIX, 8'h01}, seg);
      cmd(0, C_ERR_RESET);
      stat(0);
      @(negedge mclk_i);
      chk("lamp", 32'h0, lamp);
      cmd(1, C_JOG_FWD);
      stat(1);
      cmd(2, C_JOG_REV);
      stat(2);
      cmd(1, C_JOG_REV);
      stat(1);
      m_fs = rnd() & 32'h0000FFFF;
      wr(A_FSLIM, m_fs[31:0]);
      m_tgt = m_fs + 1;
      wr(A_TARGET, m_tgt[31:0]);
      cmd(3, C_POSN);
      stat(3);
      m_rs = -longint'(rnd() & 32'h0000FFFF) - 1;
      wr(A_RSLIM, m_rs[31:0]);
      m_tgt = m_rs - 1;
      wr(A_TARGET, m_tgt[31:0]);
      cmd(4, C_POSN);
      stat(4);
      m_tgt = m_fs;
      wr(A_TARGET, m_tgt[31:0]);
      cmd(10, C_POSN);
      stat(10);
      @(negedge mclk_i);
      chk("busy10", 32'h1, busy[10]);
      cmd(10, C_MOVE_DONE);
      cmd(5, C_ORG_RETURN);
      stat(5);
      cmd(6, C_JOG_FWD);
      stat(6);
      cmd(11, C_ORG_SEARCH);
      dcr_req[11] <= 1'b1;
      repeat (6) @(posedge mclk_i);
      flag(11, E_DCR);
      stat(11);
      cmd(7, C_JOG_FWD);
      cmd(7, C_JOG_REV);
      repeat (2) @(posedge mclk_i);
      @(negedge mclk_i);
      chk("decel7", 32'h1, decel[7]);
      stat(7);
      wr(A_OVR, {12'h000, 4'h8, OVR_MAX});
      stat(8);
      wr(A_OVR, {12'h000, 4'h8, OVR_MAX + 16'h0001});
      flag(8, E_OVR);
      stat(8);
      m_tgt = 64'sh7FFFFF00;
      wr(A_TARGET, m_tgt[31:0]);
      cmd(9, C_PRESET);
      feed(9, 256 + int'(rnd() & 32'h000007FF));
      stat(9);
      feed(9, -1);
      cmd(9, C_ERR_RESET);
      feed(9, -1);
      posck(9);
      m_tgt = rnd() & 32'h0FFFFFFF;
      wr(A_TARGET, m_tgt[31:0]);
      cmd(9, C_PRESET);
      feed(9, int'(rnd() & 32'h0000FFFF) - 32768);
      posck(9);
      m_tgt = -64'sh7FFFFFF0;
      wr(A_TARGET, m_tgt[31:0]);
      cmd(9, C_PRESET);
      feed(9, -32);
      stat(9);
      x = '0;
      lo = 0;
      for (int i = AXES - 1; i >= 0; i--) begin
         if (m_err[i] != '0) begin
            x[i] = 1'b1;
            lo = i;
         end
      end
      x[19:16] = lo[3:0];
      rdck("errsum", A_ERRSUM, x);
      @(negedge mclk_i);
      chk("seg", {16'h0000, AE_PREFIX, 8'(lo + 1)}, seg);
      chk("lamp", 32'h1, lamp);
      stop_test();
   end
endmodule
`default_nettype wire
